//--- core/arap_pkg.sv
// shared constants of the add-on register access port and its bus-side controller
package arap_pkg;
  // add-on link
  localparam int          ARAP_ADR_W        = 5;
  localparam int          ARAP_DQ_W         = 32;
  localparam int          ARAP_REGS         = 32;
  localparam logic [4:0]  ARAP_PT_ADDR_IDX  = 5'h0a;
  localparam logic [4:0]  ARAP_PT_DATA_IDX  = 5'h0b;
  localparam logic [4:0]  ARAP_STATE_IDX    = 5'h0c;
  localparam logic [4:0]  ARAP_LINT_IDX     = 5'h0d;
  // local_int_ctrl_status layout
  localparam int          ARAP_EN_MBIN_BIT  = 4;
  localparam int          ARAP_EN_MBOUT_BIT = 12;
  localparam int          ARAP_EN_BIST_BIT  = 13;
  localparam int          ARAP_ST_MBIN_BIT  = 16;
  localparam int          ARAP_ST_MBOUT_BIT = 17;
  localparam int          ARAP_ST_BIST_BIT  = 18;
  localparam int          ARAP_IRQ_ACT_BIT  = 23;
  // host-side control bits
  localparam int          ARAP_RST_CTRL_BIT = 24;
  localparam int          ARAP_HINT_EN_BIT  = 13;
  localparam logic [31:0] ARAP_REG_RESET    = 32'h0000_0000;
  // pass-thru region width codes
  localparam logic [1:0]  ARAP_PTW_8        = 2'h0;
  localparam logic [1:0]  ARAP_PTW_16       = 2'h1;
  localparam logic [1:0]  ARAP_PTW_32       = 2'h2;
  // controller register byte offsets
  localparam logic [7:0]  ARAP_C_CMD        = 8'h00;
  localparam logic [7:0]  ARAP_C_WDATA      = 8'h04;
  localparam logic [7:0]  ARAP_C_RDATA      = 8'h08;
  localparam logic [7:0]  ARAP_C_STATUS     = 8'h0c;
  localparam logic [7:0]  ARAP_C_CONFIG     = 8'h10;
  localparam logic [7:0]  ARAP_C_INTSTAT    = 8'h14;
  localparam logic [7:0]  ARAP_C_INTMASK    = 8'h18;
  // CMD fields: adr 4:0, byte_enable_n 11:8, write 16
  localparam int          ARAP_CMD_BE_LSB   = 8;
  localparam int          ARAP_CMD_WR_BIT   = 16;
  localparam logic [1:0]  ARAP_HTRANS_NSEQ  = 2'h2;
endpackage

//--- core/arap_if.sv
// add-on strobe bus between the register port and its master
`timescale 1ns/100ps
interface arap_if;
  logic        select_n;                // chip select, low active
  logic        rd_n;                    // read strobe
  logic        wr_n;                    // write strobe
  logic [4:0]  adr;                     // register address 6:2
  logic [3:0]  byte_enable_n;           // lane enables; bit 3 is word_select in half mode
  logic        half_width_select;       // high selects 16-bit data path
  logic        passthru_passive_strap;  // high selects passive pass-thru
  logic        local_int_in_n;          // level interrupt into the port
  logic        local_irq_out_n;         // interrupt out of the port
  logic        system_reset_out_n;      // buffered reset out
  logic        buffered_host_clk_out;   // buffered host clock copy
  logic [31:0] dqHostOut;               // master data out
  logic        dqHostOe;                // master drives all lanes
  logic [31:0] dqDevOut;                // port data out
  logic [3:0]  dqDevOe;                 // port lane enables
  logic [31:0] dq;                      // resolved bus, undriven lanes pulled high

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dqDevOe[i]) begin
        dq[i*8 +: 8] = dqDevOut[i*8 +: 8];
      end else if (dqHostOe) begin
        dq[i*8 +: 8] = dqHostOut[i*8 +: 8];
      end else begin
        dq[i*8 +: 8] = 8'hff;
      end
    end
  end

  modport device (
    input  select_n, rd_n, wr_n, adr, byte_enable_n, half_width_select,
           passthru_passive_strap, local_int_in_n, dq,
    output local_irq_out_n, system_reset_out_n, buffered_host_clk_out, dqDevOut, dqDevOe
  );
  modport host (
    output select_n, rd_n, wr_n, adr, byte_enable_n, half_width_select,
           passthru_passive_strap, local_int_in_n, dqHostOut, dqHostOe,
    input  local_irq_out_n, system_reset_out_n, buffered_host_clk_out, dq
  );
endinterface

//--- core/arap_device.sv
// add-on register access port: operation registers behind the strobe bus
`timescale 1ns/100ps
// Operation
// R1: all port activity on the one add-on clock
// R2: drive buffered copy of host clock
// R3: buffered reset, also forced by control bit 24
// R4: irq low on mailbox/self-test, write-one clears
// R5: pass-thru strap steers pass-thru mode only
// R6: level interrupt input raises host interrupt when enabled
// R7: width select: low 32 bits, high 16 bits
// R8: half mode: enable 3 is word select
// R9: each byte enable marks one data lane
// R10: five address inputs select the register
// R11: master asserts select only with valid controls
// R12: inputs sampled on rising edge, strobes enable
// R13: read data next cycle, else bus floats
// R14: write stored at edge sampling write strobe
// R15: half mode uses low 16 lines, steered internally
// R16: pass-thru data uses region width, not pin
// R17: half-mode dword write: low word, high word
// R18: half-mode read leaves disabled lanes floating; 8- and 16-bit pass-thru data reads drive every region lane whatever the enables; 32-bit uses the enables
// R19: disabled bytes keep previous contents
module arap_device (
  input  wire logic        clk,               // add-on clock
  input  wire logic        reset,             // async, active high
  arap_if.device           link,              // add-on strobe bus
  input  wire logic        hostClkIn,         // host clock pin
  input  wire logic        hostResetInN,      // host reset pin, low active
  input  wire logic [31:0] resetControlReg,   // host-owned reset control word
  input  wire logic [31:0] hostIntCtrlStatus, // host-owned interrupt control word
  input  wire logic        mailboxInEvent,    // pulse: incoming mailbox byte written
  input  wire logic        mailboxOutEvent,   // pulse: outgoing mailbox byte read
  input  wire logic        bistStartEvent,    // pulse: self test started
  input  wire logic [1:0]  ptRegionWidth,     // width code of the active pass-thru region
  output logic             hostIntOutN,       // host interrupt, low active
  output logic             ptPassiveMode      // pass-thru block runs passive
);
  localparam int NREG = arap_pkg::ARAP_REGS;

  logic [31:0] regFile_q [NREG];
  logic [2:0]  intStat_q;
  logic [3:0]  meta_q;
  logic [3:0]  sync_q;
  logic [31:0] rdData_q;
  logic [3:0]  rdLanes_q;
  logic        irqN_q;
  logic        sysRstN_q;
  logic        bufClk_q;
  logic        hostIntN_q;
  logic        ptPassive_q;

  logic        rdHit;
  logic        wrHit;
  logic [1:0]  width;
  logic [3:0]  wrMask;
  logic [31:0] wrData;
  logic [31:0] curVal;
  logic [2:0]  intSet;
  logic [2:0]  intClr;

  // effective data path width of an access
  function automatic logic [1:0] effWidth(input logic [4:0] idx, input logic half,
                                          input logic [1:0] ptw);
    if (idx == arap_pkg::ARAP_PT_DATA_IDX) begin
      effWidth = ptw; // [R16]
    end else if (idx == arap_pkg::ARAP_PT_ADDR_IDX || !half) begin
      effWidth = arap_pkg::ARAP_PTW_32; // [R7]
    end else begin
      effWidth = arap_pkg::ARAP_PTW_16; // [R7]
    end
  endfunction

  // lanes taken or driven; pass-thru data reads of 8- and 16-bit regions drive the whole width
  function automatic logic [3:0] laneMask(input logic [1:0] w, input logic [3:0] ben,
                                          input logic isRead, input logic ptData);
    case (w)
      arap_pkg::ARAP_PTW_32: laneMask = ~ben; // [R9]
      arap_pkg::ARAP_PTW_16: begin
        if (isRead) begin
          laneMask = ptData ? 4'h3 : {2'h0, ~ben[1:0]}; // [R18] [R15]
        end else if (ptData) begin
          laneMask = {2'h0, ~ben[1:0]};
        end else begin
          laneMask = ben[3] ? {~ben[1:0], 2'h0} : {2'h0, ~ben[1:0]}; // [R8] [R17]
        end
      end
      arap_pkg::ARAP_PTW_8: laneMask = (isRead && ptData) ? 4'h1 : {3'h0, ~ben[0]};
      default: laneMask = 4'h0;
    endcase
  endfunction

  // byte merge: lanes outside the mask keep the old byte
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] mask);
    for (int i = 0; i < 4; i++) begin
      mergeBytes[i*8 +: 8] = mask[i] ? nw[i*8 +: 8] : old[i*8 +: 8]; // [R19]
    end
  endfunction

  // strobes act only while selected; the master keeps controls valid under select
  assign rdHit = !link.select_n && !link.rd_n; // [R12] [R11]
  assign wrHit = !link.select_n && !link.wr_n; // [R12] [R11]
  assign width = effWidth(link.adr, link.half_width_select, ptRegionWidth);
  assign wrMask = wrHit ? laneMask(width, link.byte_enable_n, 1'b0,
                                   link.adr == arap_pkg::ARAP_PT_DATA_IDX) : 4'h0;

  // half-width writes replicate the low word so the mask can pick either half
  always_comb begin
    if (width == arap_pkg::ARAP_PTW_32) begin
      wrData = link.dq;
    end else begin
      wrData = {link.dq[15:0], link.dq[15:0]}; // [R15]
    end
  end

  // register value as seen by a read at the given index
  always_comb begin
    case (link.adr) // [R10]
      arap_pkg::ARAP_LINT_IDX: begin
        curVal = regFile_q[arap_pkg::ARAP_LINT_IDX];
        curVal[arap_pkg::ARAP_ST_MBIN_BIT]  = intStat_q[0];
        curVal[arap_pkg::ARAP_ST_MBOUT_BIT] = intStat_q[1];
        curVal[arap_pkg::ARAP_ST_BIST_BIT]  = intStat_q[2];
        curVal[arap_pkg::ARAP_IRQ_ACT_BIT]  = !irqN_q;
      end
      arap_pkg::ARAP_STATE_IDX: begin
        curVal = {28'h0, sync_q[1], link.half_width_select, sysRstN_q, hostIntN_q};
      end
      default: curVal = regFile_q[link.adr];
    endcase
  end

  // two-flop synchronisers for the asynchronous pins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= 4'h1;
      sync_q <= 4'h1;
    end else begin
      meta_q <= {hostClkIn, hostResetInN, link.passthru_passive_strap, link.local_int_in_n};
      sync_q <= meta_q;
    end
  end

  // operation registers; interrupt status bits live apart
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NREG; i++) begin
        regFile_q[i] <= arap_pkg::ARAP_REG_RESET;
      end
    end else if (wrHit && link.adr != arap_pkg::ARAP_STATE_IDX) begin
      regFile_q[link.adr] <= mergeBytes(regFile_q[link.adr], wrData, wrMask); // [R14] [R10]
    end
  end

  // sticky status: enable bits gate the events, set wins over clear
  always_comb begin
    intSet[0] = mailboxInEvent && regFile_q[arap_pkg::ARAP_LINT_IDX][arap_pkg::ARAP_EN_MBIN_BIT];
    intSet[1] = mailboxOutEvent
                && regFile_q[arap_pkg::ARAP_LINT_IDX][arap_pkg::ARAP_EN_MBOUT_BIT];
    intSet[2] = bistStartEvent && regFile_q[arap_pkg::ARAP_LINT_IDX][arap_pkg::ARAP_EN_BIST_BIT];
    intClr = 3'h0;
    if (wrHit && link.adr == arap_pkg::ARAP_LINT_IDX && wrMask[2]) begin
      intClr = wrData[arap_pkg::ARAP_ST_BIST_BIT:arap_pkg::ARAP_ST_MBIN_BIT]; // [R4]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      intStat_q <= 3'h0;
      irqN_q    <= 1'b1;
    end else begin
      intStat_q <= intSet | (intStat_q & ~intClr); // [R4]
      irqN_q    <= ~|(intSet | (intStat_q & ~intClr)); // [R4]
    end
  end

  // read data appears one cycle after the sampled strobe, lanes released otherwise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdData_q  <= 32'h0;
      rdLanes_q <= 4'h0;
    end else if (rdHit) begin
      rdLanes_q <= laneMask(width, link.byte_enable_n, 1'b1,
                            link.adr == arap_pkg::ARAP_PT_DATA_IDX); // [R13] [R18]
      if (width == arap_pkg::ARAP_PTW_16 && link.adr != arap_pkg::ARAP_PT_DATA_IDX) begin
        rdData_q <= {16'h0, link.byte_enable_n[3] ? curVal[31:16] : curVal[15:0]}; // [R8] [R15]
      end else begin
        rdData_q <= curVal;
      end
    end else begin
      rdLanes_q <= 4'h0; // [R13]
    end
  end

  // system side copies; the clock copy is resampled, so only slow host clocks pass cleanly
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sysRstN_q   <= 1'b0;
      bufClk_q    <= 1'b0;
      hostIntN_q  <= 1'b1;
      ptPassive_q <= 1'b0;
    end else begin
      sysRstN_q   <= sync_q[2] && !resetControlReg[arap_pkg::ARAP_RST_CTRL_BIT]; // [R3]
      bufClk_q    <= sync_q[3]; // [R2] [R1]
      hostIntN_q  <= !(hostIntCtrlStatus[arap_pkg::ARAP_HINT_EN_BIT] && !sync_q[0]); // [R6]
      ptPassive_q <= sync_q[1]; // [R5]
    end
  end

  assign link.dqDevOut              = rdData_q;
  assign link.dqDevOe               = rdLanes_q;
  assign link.local_irq_out_n       = irqN_q;
  assign link.system_reset_out_n    = sysRstN_q;
  assign link.buffered_host_clk_out = bufClk_q;
  assign hostIntOutN                = hostIntN_q;
  assign ptPassiveMode              = ptPassive_q;
endmodule

//--- core/arap_host.sv
// add-on bus master driven from AHB-Lite registers
`timescale 1ns/100ps
module arap_host (
  input  wire logic        clk,        // add-on clock
  input  wire logic        reset,      // async, active high
  arap_if.host             link,       // add-on strobe bus
  input  wire logic        hsel,       // AHB slave select
  input  wire logic [31:0] haddr,      // AHB address
  input  wire logic [1:0]  htrans,     // AHB transfer type
  input  wire logic        hwrite,     // AHB write
  input  wire logic [2:0]  hsize,      // AHB size, word only
  input  wire logic [31:0] hwdata,     // AHB write data
  input  wire logic        hready,     // AHB bus ready
  output logic             hreadyout,  // AHB slave ready
  output logic             hresp,      // AHB response, always OKAY
  output logic [31:0]      hrdata,     // AHB read data
  output logic             irq         // level interrupt
);
  typedef enum logic [1:0] {IDLE, STROBE, CAPTURE} arap_state_e;

  arap_state_e state_q;
  logic [7:0]  aAddr_q;
  logic        aWrite_q;
  logic        dPhase_q;
  logic        hready_q;
  logic [31:0] hrdata_q;
  logic [31:0] cmd_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [2:0]  cfg_q;
  logic        intStat_q;
  logic        intMask_q;
  logic        irq_q;
  logic        sel_q;
  logic        rd_q;
  logic        wr_q;
  logic        dqOe_q;
  logic        busWr;
  logic        cmdGo;
  logic        doneEv;
  logic [31:0] readMux;

  assign busWr  = dPhase_q && aWrite_q;
  assign cmdGo  = busWr && aAddr_q == arap_pkg::ARAP_C_CMD && state_q == IDLE;
  assign doneEv = (state_q == STROBE && wr_q) || state_q == CAPTURE;

  always_comb begin
    case (aAddr_q)
      arap_pkg::ARAP_C_CMD:     readMux = cmd_q;
      arap_pkg::ARAP_C_WDATA:   readMux = wdata_q;
      arap_pkg::ARAP_C_RDATA:   readMux = rdata_q;
      arap_pkg::ARAP_C_STATUS:  readMux = {31'h0, state_q != IDLE};
      arap_pkg::ARAP_C_CONFIG:  readMux = {29'h0, cfg_q};
      arap_pkg::ARAP_C_INTSTAT: readMux = {31'h0, intStat_q};
      arap_pkg::ARAP_C_INTMASK: readMux = {31'h0, intMask_q};
      default:                  readMux = 32'h0;
    endcase
  end

  // one wait state: address phase latched, answer registered in the data phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aAddr_q  <= 8'h0;
      aWrite_q <= 1'b0;
      dPhase_q <= 1'b0;
      hready_q <= 1'b1;
      hrdata_q <= 32'h0;
    end else if (dPhase_q) begin
      dPhase_q <= 1'b0;
      hready_q <= 1'b1;
      hrdata_q <= aWrite_q ? 32'h0 : readMux;
    end else if (hsel && hready && htrans == arap_pkg::ARAP_HTRANS_NSEQ) begin
      aAddr_q  <= haddr[7:0];
      aWrite_q <= hwrite;
      dPhase_q <= 1'b1;
      hready_q <= 1'b0;
    end
  end

  // controller registers; CMD written while busy is dropped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_q     <= 32'h0000_0f00;
      wdata_q   <= 32'h0;
      cfg_q     <= 3'h4;
      intMask_q <= 1'b0;
    end else if (busWr) begin
      case (aAddr_q)
        arap_pkg::ARAP_C_CMD:     if (cmdGo) cmd_q <= hwdata;
        arap_pkg::ARAP_C_WDATA:   wdata_q <= hwdata;
        arap_pkg::ARAP_C_CONFIG:  cfg_q <= hwdata[2:0];
        arap_pkg::ARAP_C_INTMASK: intMask_q <= hwdata[0];
        default: ;
      endcase
    end
  end

  // done flag: set wins over a write-one clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      intStat_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      intStat_q <= doneEv || (intStat_q && !(busWr && aAddr_q == arap_pkg::ARAP_C_INTSTAT
                                             && hwdata[0]));
      irq_q     <= intStat_q && intMask_q;
    end
  end

  // strobe sequencer: one select cycle; reads capture two edges after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= IDLE;
      sel_q   <= 1'b0;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      dqOe_q  <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      case (state_q)
        IDLE: begin
          if (cmdGo) begin
            state_q <= STROBE;
            sel_q   <= 1'b1;
            rd_q    <= !hwdata[arap_pkg::ARAP_CMD_WR_BIT];
            wr_q    <= hwdata[arap_pkg::ARAP_CMD_WR_BIT];
            dqOe_q  <= hwdata[arap_pkg::ARAP_CMD_WR_BIT];
          end
        end
        STROBE: begin
          sel_q   <= 1'b0;
          rd_q    <= 1'b0;
          wr_q    <= 1'b0;
          dqOe_q  <= 1'b0;
          state_q <= rd_q ? CAPTURE : IDLE;
        end
        CAPTURE: begin
          rdata_q <= link.dq;
          state_q <= IDLE;
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  assign link.select_n               = !sel_q;
  assign link.rd_n                   = !rd_q;
  assign link.wr_n                   = !wr_q;
  assign link.adr                    = cmd_q[4:0];
  assign link.byte_enable_n          = cmd_q[arap_pkg::ARAP_CMD_BE_LSB +: 4];
  assign link.dqHostOut              = wdata_q;
  assign link.dqHostOe               = dqOe_q;
  assign link.half_width_select      = cfg_q[0];
  assign link.passthru_passive_strap = cfg_q[1];
  assign link.local_int_in_n         = cfg_q[2];
  assign hreadyout                   = hready_q;
  assign hresp                       = 1'b0;
  assign hrdata                      = hrdata_q;
  assign irq                         = irq_q;
endmodule

//--- test/arap_link_assertions.sv
// concurrent checks on the add-on strobe bus between controller and port
`timescale 1ns/100ps
module arap_link_assertions (
  input wire logic       clk,               // add-on clock
  input wire logic       reset,             // async, active high
  input wire logic       select_n,          // chip select
  input wire logic       rd_n,              // read strobe
  input wire logic       wr_n,              // write strobe
  input wire logic [4:0] adr,               // register index
  input wire logic [3:0] byte_enable_n,     // lane enables
  input wire logic       half_width_select, // 16-bit path
  input wire logic       local_irq_out_n,   // port interrupt
  input wire logic       dqHostOe,          // master drives data
  input wire logic [3:0] dqDevOe            // port lane drive
);
  logic lintWr_q;  // interrupt register written at the last edge

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lintWr_q <= 1'b0;
    end else begin
      lintWr_q <= !select_n && !wr_n && (adr == arap_pkg::ARAP_LINT_IDX);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_read_lanes_full: assert property (
    (!select_n && !rd_n && !half_width_select && adr != arap_pkg::ARAP_PT_DATA_IDX)
    |=> dqDevOe == ~$past(byte_enable_n)) else $error("full-width read lanes wrong");
  a_read_lanes_half: assert property (
    (!select_n && !rd_n && half_width_select && adr != arap_pkg::ARAP_PT_DATA_IDX &&
     adr != arap_pkg::ARAP_PT_ADDR_IDX)
    |=> dqDevOe == ((~$past(byte_enable_n)) & 4'h3)) else $error("half read lanes wrong");
  a_bus_floats: assert property (
    (select_n || rd_n) |=> dqDevOe == 4'h0) else $error("data driven without read");
  a_irq_clear_cause: assert property (
    $rose(local_irq_out_n) |-> lintWr_q) else $error("interrupt released without clear");
  a_select_qualifies: assert property (
    (!rd_n || !wr_n) |-> !select_n) else $error("strobe without chip select");
  a_rd_one_cycle: assert property (
    !rd_n |=> rd_n) else $error("read strobe held too long");
  a_wr_drives_data: assert property (
    !wr_n |-> dqHostOe) else $error("write without data");
  a_no_contention: assert property (
    dqHostOe |-> dqDevOe == 4'h0) else $error("both ends drive data");
endmodule

//--- test/tb_top.sv
// self-checking bench: AHB-Lite master working the port through its controller
`timescale 1ns/100ps
module tb_top;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [31:0] hrdata;
  logic        hostClk = 1'b0;
  logic        hostRstN = 1'b1;
  logic [31:0] rstCtrl = 32'h0;
  logic [31:0] hostIcs = 32'h0;
  logic [2:0]  events = 3'h0;
  logic [1:0]  ptWidth = 2'h2;
  logic        hostIntN;
  logic        ptPassive;
  logic [31:0] rd;
  int          miscompares = 0;
  int          comparisons = 0;
  int          bufRises = 0;
  logic        bufPrev = 1'b0;

  arap_if link ();

  always #20 clk = ~clk;
  // host clock unrelated in phase to the add-on clock
  always #170 hostClk = ~hostClk;

  // rising edges of the clock copy, counted on the add-on clock
  always @(posedge clk) begin
    bufPrev <= link.buffered_host_clk_out;
    if (link.buffered_host_clk_out && !bufPrev) begin
      bufRises <= bufRises + 1;
    end
  end

  arap_device arap_device_i (.clk(clk), .reset(reset), .link(link.device),
    .hostClkIn(hostClk), .hostResetInN(hostRstN), .resetControlReg(rstCtrl),
    .hostIntCtrlStatus(hostIcs), .mailboxInEvent(events[0]), .mailboxOutEvent(events[1]),
    .bistStartEvent(events[2]), .ptRegionWidth(ptWidth), .hostIntOutN(hostIntN),
    .ptPassiveMode(ptPassive));
  arap_host arap_host_i (.clk(clk), .reset(reset), .link(link.host), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
  arap_link_assertions arap_link_assertions_i (.clk(clk), .reset(reset),
    .select_n(link.select_n), .rd_n(link.rd_n), .wr_n(link.wr_n), .adr(link.adr),
    .byte_enable_n(link.byte_enable_n), .half_width_select(link.half_width_select),
    .local_irq_out_n(link.local_irq_out_n), .dqHostOe(link.dqHostOe),
    .dqDevOe(link.dqDevOe));

  task automatic wrap_up;
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= arap_pkg::ARAP_HTRANS_NSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // one strobe-bus access through the controller, polled until it is done
  task automatic op(input logic w, input logic [4:0] a, input logic [3:0] ben,
                    input logic [31:0] d, output logic [31:0] r);
    if (w) ahb(1'b1, arap_pkg::ARAP_C_WDATA, d, r);
    ahb(1'b1, arap_pkg::ARAP_C_CMD, {15'h0, w, 4'h0, ben, 3'h0, a}, r);
    do ahb(1'b0, arap_pkg::ARAP_C_STATUS, 32'h0, r); while (r[0] !== 1'b0);
    if (!w) ahb(1'b0, arap_pkg::ARAP_C_RDATA, 32'h0, r);
  endtask

  task automatic pulse(input int k);
    events[k] <= 1'b1;
    @(posedge clk);
    events <= 3'h0;
    repeat (2) @(posedge clk);
  endtask

  // synchronisers on the host-side pins need a few cycles to follow
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    settle();
    chk("system_reset_out_n", 32'h1, link.system_reset_out_n);
    // half period is 4.25 add-on cycles, so 34 cycles hold four host periods
    rd = bufRises;
    repeat (34) @(posedge clk);
    rd = bufRises - rd;
    comparisons++;
    if (rd < 32'h3 || rd > 32'h5) begin
      miscompares++;
      $display("unexpected buffered_host_clk_out rises expected %h seen %h", 32'h4, rd);
    end
    ahb(1'b1, arap_pkg::ARAP_C_INTMASK, 32'h1, rd);
    op(1'b1, 5'h01, 4'h0, 32'h1234_5678, rd);
    op(1'b0, 5'h01, 4'h0, 32'h0, rd);
    chk("reg1", 32'h1234_5678, rd);
    chk("irq", 32'h1, irq);
    ahb(1'b1, arap_pkg::ARAP_C_INTSTAT, 32'h1, rd);
    ahb(1'b0, arap_pkg::ARAP_C_STATUS, 32'h0, rd);
    chk("irq cleared", 32'h0, irq);
    op(1'b1, 5'h01, 4'b1010, 32'haabb_ccdd, rd);
    op(1'b0, 5'h01, 4'h0, 32'h0, rd);
    chk("reg1 partial", 32'h12bb_56dd, rd);
    op(1'b0, 5'h01, 4'b0110, 32'h0, rd);
    chk("reg1 lanes", 32'h12ff_ffdd, rd);
    op(1'b0, 5'h02, 4'h0, 32'h0, rd);
    chk("reg2", 32'h0, rd);
    ahb(1'b0, 8'h1c, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, hresp);
    // half width: word select on enable 3, enable 2 ignored
    ahb(1'b1, arap_pkg::ARAP_C_CONFIG, 32'h5, rd);
    op(1'b1, 5'h02, 4'b0100, 32'h0000_5678, rd);
    op(1'b1, 5'h02, 4'b1010, 32'h0000_0034, rd);
    op(1'b1, 5'h02, 4'b1001, 32'h0000_1200, rd);
    op(1'b0, 5'h02, 4'b1000, 32'h0, rd);
    chk("reg2 high", 32'hffff_1234, rd);
    op(1'b0, 5'h02, 4'b0001, 32'h0, rd);
    chk("reg2 low", 32'hffff_56ff, rd);
    ahb(1'b1, arap_pkg::ARAP_C_CONFIG, 32'h4, rd);
    op(1'b0, 5'h02, 4'h0, 32'h0, rd);
    chk("reg2 full", 32'h1234_5678, rd);
    op(1'b1, 5'h0b, 4'h0, 32'hcafe_f00d, rd);
    ptWidth <= 2'h1;
    ahb(1'b1, arap_pkg::ARAP_C_CONFIG, 32'h5, rd);
    op(1'b0, 5'h0b, 4'b1011, 32'h0, rd);
    chk("pt data", 32'hffff_f00d, rd);
    ptWidth <= 2'h0;
    op(1'b0, 5'h0b, 4'h0, 32'h0, rd);
    chk("pt data byte", 32'hffff_ff0d, rd);
    op(1'b1, 5'h0a, 4'h0, 32'h8765_4321, rd);
    op(1'b0, 5'h0a, 4'h0, 32'h0, rd);
    chk("pt addr", 32'h8765_4321, rd);
    ahb(1'b1, arap_pkg::ARAP_C_CONFIG, 32'h4, rd);
    // port interrupt: enabled sources only, write one to release
    op(1'b1, 5'h0d, 4'b1100, 32'h0000_2010, rd);
    pulse(1);
    chk("irq_out_n disabled", 32'h1, link.local_irq_out_n);
    pulse(0);
    chk("irq_out_n mailbox", 32'h0, link.local_irq_out_n);
    op(1'b0, 5'h0d, 4'h0, 32'h0, rd);
    chk("int status", 32'h0081_2010, rd);
    op(1'b1, 5'h0d, 4'b1011, 32'h0001_0000, rd);
    chk("irq_out_n cleared", 32'h1, link.local_irq_out_n);
    pulse(2);
    chk("irq_out_n selftest", 32'h0, link.local_irq_out_n);
    op(1'b1, 5'h0d, 4'b1011, 32'h0004_0000, rd);
    chk("irq_out_n cleared", 32'h1, link.local_irq_out_n);
    // strap and level interrupt input via the controller's config
    ahb(1'b1, arap_pkg::ARAP_C_CONFIG, 32'h2, rd);
    settle();
    chk("hostIntOutN masked", 32'h1, hostIntN);
    chk("ptPassiveMode", 32'h1, ptPassive);
    hostIcs <= 32'h0000_2000;
    settle();
    chk("hostIntOutN", 32'h0, hostIntN);
    rstCtrl <= 32'h0100_0000;
    settle();
    chk("system_reset_out_n forced", 32'h0, link.system_reset_out_n);
    rstCtrl <= 32'h0;
    hostRstN <= 1'b0;
    settle();
    chk("system_reset_out_n host", 32'h0, link.system_reset_out_n);
    op(1'b0, arap_pkg::ARAP_STATE_IDX, 4'h0, 32'h0, rd);
    chk("state", 32'h8, rd);
    hostRstN <= 1'b1;
    settle();
    chk("system_reset_out_n free", 32'h1, link.system_reset_out_n);
    wrap_up();
  end
endmodule
